// ==== gpr_pkg.sv ====
// Purpose: shared constants and carriers for the gating pulse observe router
// Assumes: 20 MHz system clock, plain register port with 32-bit data
// Notes:   jumper pins read 1 when open and 0 when closed
`default_nettype none

package gpr_pkg;

    // register port geometry
    localparam int          GPR_ADDR_W      = 8;
    localparam int          GPR_DATA_W      = 32;

    // register offsets (byte addresses)
    localparam logic [7:0]  GPR_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  GPR_ADDR_STATUS = 8'h04;

    // control register layout
    localparam int          GPR_CTRL_OVR    = 0;
    localparam int          GPR_CTRL_CFG_LO = 1;
    localparam int          GPR_CTRL_W      = 5;
    localparam logic [4:0]  GPR_CTRL_RST    = 5'h00;

    // status register layout
    localparam int          GPR_ST_CFG_LO   = 0;
    localparam int          GPR_ST_JMP_LO   = 4;
    localparam int          GPR_ST_OUT_LO   = 8;

    // pin synchroniser depth and clock
    localparam int          GPR_CLK_HZ      = 20_000_000;
    localparam int          GPR_SYNC_STAGES = 3;

    // option settings, one bit each, in the level a jumper pin presents
    typedef struct packed {
        logic tx_polarity_setting;
        logic rx_polarity_setting;
        logic one_pulse_mode;
        logic three_select_mode;
    } gpr_cfg_s;

    localparam int          GPR_CFG_W       = 4;

    // all pin inputs of the router
    typedef struct packed {
        logic       rx_gate_in_a;
        logic       rx_gate_in_b;
        logic [2:0] tx_gate_n;
        logic [2:0] observe_sel_n;
        gpr_cfg_s   jumpers;
    } gpr_pins_s;

    localparam int          GPR_PIN_W       = 12;
    // idle pins: gates and selects inactive, jumpers open
    localparam logic [11:0] GPR_PIN_RST     = 12'hfff;

    // all router outputs
    typedef struct packed {
        logic       receiver_pulse;
        logic [2:0] observe_pulse;
        logic [2:0] tx_switch;
        logic [2:0] osc_path_sel_n;
        logic       osc_path_enable;
    } gpr_out_s;

    localparam int          GPR_OUT_W       = 11;
    localparam logic [10:0] GPR_OUT_RST     = 11'h00e;

endpackage : gpr_pkg

`default_nettype wire

// ==== gpr_pin_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to clk_in
// Notes:   output changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module gpr_pin_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // raw and filtered levels
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
        end else begin
            stage1 <= d_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // per bit: a level that has not settled over two stages is not passed on
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_out <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    q_out[i] <= stage3[i];
                end
            end
        end
    end

endmodule : gpr_pin_sync

`default_nettype wire

// ==== gpr_router.sv ====
// Purpose: route console gating pulses and observe selects to the
//          receiver, transmitter switches and oscillator path switch
// Assumes: pins are asynchronous; jumpers read 1 open, 0 closed
// Notes:   outputs are registered, four to five clocks behind the pins
//
// Functional notes
// - tx jumper sets tx gate sense
// - rx jumper sets rx gate sense
// - pulse-count jumper picks A or B
// - select-mode jumper: three selects or one
// - receiver pulse always follows corrected input A
// - channel one observes when only it selected
// - channel two observes when only it selected
// - channel three observes only in three-select
// - single select: channel two select picks channel
// - oscillator selects low with matching observe pulse
// - oscillator enable is OR of observes
// - defaults: all jumpers open
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module gpr_router
    import gpr_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  sys_rst_in,
    // console gating pulses
    input  wire logic                  rx_gate_in_a_in,
    input  wire logic                  rx_gate_in_b_in,
    input  wire logic                  tx_gate_in_ch1_n_in,
    input  wire logic                  tx_gate_in_ch2_n_in,
    input  wire logic                  tx_gate_in_ch3_n_in,
    // observe selects
    input  wire logic                  observe_sel_ch1_n_in,
    input  wire logic                  observe_sel_ch2_n_in,
    input  wire logic                  observe_sel_ch3_n_in,
    // option jumpers
    input  wire logic                  tx_polarity_jumper_in,
    input  wire logic                  rx_polarity_jumper_in,
    input  wire logic                  pulse_count_jumper_in,
    input  wire logic                  select_mode_jumper_in,
    // register port
    input  wire logic [GPR_ADDR_W-1:0] reg_addr_in,
    input  wire logic [GPR_DATA_W-1:0] reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output var  logic [GPR_DATA_W-1:0] reg_rdata_out,
    // receiver and observe pulses
    output var  logic                  receiver_pulse_out,
    output var  logic                  observe_pulse_ch1_out,
    output var  logic                  observe_pulse_ch2_out,
    output var  logic                  observe_pulse_ch3_out,
    // transmitter switching pulses
    output var  logic                  tx_switch_ch1_out,
    output var  logic                  tx_switch_ch2_out,
    output var  logic                  tx_switch_ch3_out,
    // oscillator path switch
    output var  logic                  osc_path_sel1_n_out,
    output var  logic                  osc_path_sel2_n_out,
    output var  logic                  osc_path_sel3_n_out,
    output var  logic                  osc_path_enable_out
);

    gpr_pins_s              pins_raw;
    gpr_pins_s              pins;
    logic [GPR_CTRL_W-1:0]  ctrl;
    gpr_cfg_s               sw_cfg;
    gpr_cfg_s               cfg;
    gpr_out_s               next_outs;
    gpr_out_s               outs;

    logic                   rx_pulse_int_a;
    logic                   rx_pulse_int_b;
    logic                   chosen_pulse;
    logic                   obs_ch2;

    // gather the pins into one carrier
    always_comb begin
        pins_raw.rx_gate_in_a                  = rx_gate_in_a_in;
        pins_raw.rx_gate_in_b                  = rx_gate_in_b_in;
        pins_raw.tx_gate_n                     = {tx_gate_in_ch3_n_in,
                                                  tx_gate_in_ch2_n_in,
                                                  tx_gate_in_ch1_n_in};
        pins_raw.observe_sel_n                 = {observe_sel_ch3_n_in,
                                                  observe_sel_ch2_n_in,
                                                  observe_sel_ch1_n_in};
        pins_raw.jumpers.tx_polarity_setting   = tx_polarity_jumper_in;
        pins_raw.jumpers.rx_polarity_setting   = rx_polarity_jumper_in;
        pins_raw.jumpers.one_pulse_mode        = pulse_count_jumper_in;
        pins_raw.jumpers.three_select_mode     = select_mode_jumper_in;
    end

    // jumpers pass the filter too, so a reworked jumper settles before use
    gpr_pin_sync #(
        .W       (GPR_PIN_W),
        .RST_VAL (GPR_PIN_RST)
    ) u_pin_sync (
        .clk_in (mclk_in),
        .rst_in (sys_rst_in),
        .d_in   (pins_raw),
        .q_out  (pins)
    );

    // software may take over the jumper settings, e.g. for bench tests
    // without rework; the override is off after reset
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ctrl <= GPR_CTRL_RST;
        end else if (reg_wr_in && reg_addr_in == GPR_ADDR_CTRL) begin
            ctrl <= reg_wdata_in[GPR_CTRL_W-1:0];
        end
    end

    assign sw_cfg = gpr_cfg_s'(ctrl[GPR_CTRL_CFG_LO +: GPR_CFG_W]);
    // jumper pin level is the setting itself: open = 1 = low-active
    assign cfg    = ctrl[GPR_CTRL_OVR] ? sw_cfg : pins.jumpers;

    // one channel alone selected; a double select must observe nothing
    function automatic logic sole_select(input logic [2:0] sel_n,
                                         input int         idx);
        logic [2:0] want_n;
        want_n      = '1;
        want_n[idx] = 1'b0;
        return sel_n == want_n;
    endfunction : sole_select

    // polarity correction and pulse choice
    always_comb begin
        rx_pulse_int_a = pins.rx_gate_in_a ^ cfg.rx_polarity_setting;
        rx_pulse_int_b = pins.rx_gate_in_b ^ cfg.rx_polarity_setting;
        chosen_pulse   = cfg.one_pulse_mode ? rx_pulse_int_a
                                            : rx_pulse_int_b;
        // console single line is wired onto the channel two select
        obs_ch2        = ~pins.observe_sel_n[1];
    end

    // routing; a multiple selection in three-select mode observes nothing
    always_comb begin
        next_outs.receiver_pulse = rx_pulse_int_a;
        next_outs.tx_switch      = pins.tx_gate_n
                                 ^ {3{cfg.tx_polarity_setting}};
        if (cfg.three_select_mode) begin
            next_outs.observe_pulse[0] = sole_select(pins.observe_sel_n, 0)
                                       & chosen_pulse;
            next_outs.observe_pulse[1] = sole_select(pins.observe_sel_n, 1)
                                       & chosen_pulse;
            next_outs.observe_pulse[2] = sole_select(pins.observe_sel_n, 2)
                                       & chosen_pulse;
        end else begin
            next_outs.observe_pulse[0] = ~obs_ch2 & chosen_pulse;
            next_outs.observe_pulse[1] = obs_ch2 & chosen_pulse;
            next_outs.observe_pulse[2] = 1'b0;
        end
        next_outs.osc_path_sel_n  = ~next_outs.observe_pulse;
        next_outs.osc_path_enable = |next_outs.observe_pulse;
    end

    // one more clock of delay, but no decode glitch reaches the switches
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            outs <= GPR_OUT_RST;
        end else begin
            outs <= next_outs;
        end
    end

    assign receiver_pulse_out    = outs.receiver_pulse;
    assign observe_pulse_ch1_out = outs.observe_pulse[0];
    assign observe_pulse_ch2_out = outs.observe_pulse[1];
    assign observe_pulse_ch3_out = outs.observe_pulse[2];
    assign tx_switch_ch1_out     = outs.tx_switch[0];
    assign tx_switch_ch2_out     = outs.tx_switch[1];
    assign tx_switch_ch3_out     = outs.tx_switch[2];
    assign osc_path_sel1_n_out   = outs.osc_path_sel_n[0];
    assign osc_path_sel2_n_out   = outs.osc_path_sel_n[1];
    assign osc_path_sel3_n_out   = outs.osc_path_sel_n[2];
    assign osc_path_enable_out   = outs.osc_path_enable;

    // read data stand only in the cycle after the strobe
    // status: effective settings, filtered jumpers, then the outputs
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in && reg_addr_in == GPR_ADDR_CTRL) begin
            reg_rdata_out <= GPR_DATA_W'(ctrl);
        end else if (reg_rd_in && reg_addr_in == GPR_ADDR_STATUS) begin
            reg_rdata_out <= '0;
            reg_rdata_out[GPR_ST_CFG_LO +: GPR_CFG_W] <= cfg;
            reg_rdata_out[GPR_ST_JMP_LO +: GPR_CFG_W] <= pins.jumpers;
            reg_rdata_out[GPR_ST_OUT_LO +: GPR_OUT_W] <= outs;
        end else begin
            reg_rdata_out <= '0;
        end
    end

    // checks

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    // keeps $past from reaching back across a reset edge
    logic past_valid;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            past_valid <= 1'b0;
        end else begin
            past_valid <= 1'b1;
        end
    end

    a_tx_switch_sense: assert property (
        past_valid |-> tx_switch_ch2_out ==
            ($past(pins.tx_gate_n[1]) ^ $past(cfg.tx_polarity_setting)))
        else $error("tx switch sense wrong");

    a_tx_switch_ch1: assert property (
        past_valid |-> tx_switch_ch1_out ==
            ($past(pins.tx_gate_n[0]) ^ $past(cfg.tx_polarity_setting)))
        else $error("tx switch one sense wrong");

    a_tx_switch_ch3: assert property (
        past_valid |-> tx_switch_ch3_out ==
            ($past(pins.tx_gate_n[2]) ^ $past(cfg.tx_polarity_setting)))
        else $error("tx switch three sense wrong");

    a_rx_pulse_sense: assert property (
        past_valid |-> receiver_pulse_out ==
            ($past(pins.rx_gate_in_a) ^ $past(cfg.rx_polarity_setting)))
        else $error("receiver pulse sense wrong");

    a_two_pulse_source: assert property (
        past_valid && $past(!cfg.one_pulse_mode)
            && $past(!cfg.three_select_mode)
            && $past(pins.observe_sel_n[1])
        |-> observe_pulse_ch1_out ==
            $past(pins.rx_gate_in_b ^ cfg.rx_polarity_setting))
        else $error("two-pulse mode did not use input b");

    a_two_pulse_ch2: assert property (
        past_valid && $past(!cfg.one_pulse_mode)
            && $past(cfg.three_select_mode)
            && $past(pins.observe_sel_n) == 3'b101
        |-> observe_pulse_ch2_out ==
            $past(pins.rx_gate_in_b ^ cfg.rx_polarity_setting))
        else $error("two-pulse mode did not use input b on channel two");

    a_single_no_ch3: assert property (
        past_valid && $past(!cfg.three_select_mode)
        |-> !observe_pulse_ch3_out && osc_path_sel3_n_out)
        else $error("channel three observed in single-select mode");

    a_obs_exclusive: assert property (
        $onehot0({observe_pulse_ch3_out, observe_pulse_ch2_out,
                  observe_pulse_ch1_out}))
        else $error("more than one observe pulse");

    a_obs_ch1_sel: assert property (
        past_valid && observe_pulse_ch1_out && $past(cfg.three_select_mode)
        |-> $past(pins.observe_sel_n) == 3'b110)
        else $error("channel one observed without sole select");

    a_obs_ch1_pulse: assert property (
        past_valid && $past(cfg.three_select_mode)
            && $past(cfg.one_pulse_mode)
            && $past(pins.observe_sel_n) == 3'b110
        |-> observe_pulse_ch1_out == receiver_pulse_out)
        else $error("channel one not observed while alone selected");

    a_obs_ch2_sel: assert property (
        past_valid && observe_pulse_ch2_out && $past(cfg.three_select_mode)
        |-> $past(pins.observe_sel_n) == 3'b101)
        else $error("channel two observed without sole select");

    a_obs_ch3_sel: assert property (
        past_valid && observe_pulse_ch3_out
        |-> $past(cfg.three_select_mode)
            && $past(pins.observe_sel_n) == 3'b011)
        else $error("channel three observed without sole select");

    a_obs_ch3_pulse: assert property (
        past_valid && $past(cfg.three_select_mode)
            && $past(cfg.one_pulse_mode)
            && $past(pins.observe_sel_n) == 3'b011
        |-> observe_pulse_ch3_out == receiver_pulse_out)
        else $error("channel three not observed while alone selected");

    a_single_follow: assert property (
        past_valid && $past(!cfg.three_select_mode)
            && $past(cfg.one_pulse_mode)
        |-> (observe_pulse_ch1_out || observe_pulse_ch2_out) ==
            receiver_pulse_out)
        else $error("single-select observe does not follow pulse");

    a_single_ch2: assert property (
        past_valid && $past(!cfg.three_select_mode)
            && $past(cfg.one_pulse_mode)
        |-> observe_pulse_ch2_out ==
            ($past(!pins.observe_sel_n[1]) && receiver_pulse_out))
        else $error("single-select channel two ignores its select");

    a_osc_select_low: assert property (
        {osc_path_sel3_n_out, osc_path_sel2_n_out, osc_path_sel1_n_out} ==
        ~{observe_pulse_ch3_out, observe_pulse_ch2_out,
          observe_pulse_ch1_out})
        else $error("oscillator select disagrees with observe pulse");

    a_osc_enable_or: assert property (
        osc_path_enable_out == (observe_pulse_ch1_out
            || observe_pulse_ch2_out || observe_pulse_ch3_out))
        else $error("oscillator enable is not the observe or");

    a_default_open: assert property (
        $fell(sys_rst_in) |-> cfg == {GPR_CFG_W{1'b1}})
        else $error("settings after reset are not all open");

    a_pin_latency: assert property (
        $rose(pins.rx_gate_in_a) && !cfg.rx_polarity_setting
            && $stable(cfg.rx_polarity_setting)
        |=> receiver_pulse_out)
        else $error("receiver pulse did not follow pin");

    a_rdata_one_cycle: assert property (
        past_valid && !$past(reg_rd_in) |-> reg_rdata_out == '0)
        else $error("read data present without a read");

    a_ctrl_write: assert property (
        past_valid && $past(reg_wr_in && reg_addr_in == GPR_ADDR_CTRL)
        |-> ctrl == $past(reg_wdata_in[GPR_CTRL_W-1:0]))
        else $error("control write not taken");

    a_reset_outputs: assert property (
        $fell(sys_rst_in) |-> outs == GPR_OUT_RST)
        else $error("outputs not idle after reset");

    c_three_sel_ch2: cover property (
        cfg.three_select_mode && observe_pulse_ch2_out);
    c_single_ch1: cover property (
        !cfg.three_select_mode && observe_pulse_ch1_out);
    c_two_pulse: cover property (
        !cfg.one_pulse_mode && observe_pulse_ch3_out);
    c_read_status: cover property (
        reg_rd_in && reg_addr_in == GPR_ADDR_STATUS);
    c_double_select: cover property (
        cfg.three_select_mode && pins.observe_sel_n == 3'b100);

endmodule : gpr_router

`default_nettype wire

// ==== gpr_console.sv ====
// Purpose: console model driving gating pulses and observe selects
// Assumes: a pattern is loaded on the same edge that sees load_in high
// Notes:   in single-select mode the console line rides on the ch2 pin
`timescale 1ns/1ps
`default_nettype none

module gpr_console (
    // clock and pattern request
    input  wire logic       mclk_in,
    input  wire logic       load_in,
    input  wire logic       single_in,
    input  wire logic       line_in,
    input  wire logic [7:0] pat_in,
    // console pins
    output var  logic       gate_a_out,
    output var  logic       gate_b_out,
    output var  logic [2:0] tx_gate_n_out,
    output var  logic [2:0] sel_n_out
);
    // pins start idle-high, as an unpowered console pulled up
    initial begin
        gate_a_out    = 1'b1;
        gate_b_out    = 1'b1;
        tx_gate_n_out = 3'h7;
        sel_n_out     = 3'h7;
    end

    always @(posedge mclk_in) begin
        if (load_in) begin
            gate_a_out    <= pat_in[7];
            gate_b_out    <= pat_in[6];
            tx_gate_n_out <= pat_in[5:3];
            // unused selects keep random levels: the logic must ignore them
            sel_n_out     <= single_in ? {pat_in[2], line_in, pat_in[0]}
                                       : pat_in[2:0];
        end
    end
endmodule : gpr_console

`default_nettype wire

// ==== gpr_router_tb.sv ====
// Purpose: self-checking bench for the gating pulse observe router
// Assumes: pins held 8 clocks before outputs are compared
// Notes:   cfg nibble order is {tx, rx, one pulse, three select}
`timescale 1ns/1ps
`default_nettype none

module gpr_router_tb;
    import gpr_pkg::*;

    logic              mclk_in     = 1'b0;
    logic              sys_rst_in  = 1'b1;
    logic              load        = 1'b0;
    logic              single      = 1'b0;
    logic              line        = 1'b1;
    logic [7:0]        pat         = 8'hff;
    logic [3:0]        jmp         = 4'hf;
    logic [7:0]        addr        = 8'h00;
    logic [31:0]       wdata       = 32'h0;
    logic              wr          = 1'b0;
    logic              rd          = 1'b0;
    logic [31:0]       seed        = 32'h77573d3c;
    logic [4:0]        ctrl        = 5'h00;
    int                miscompares = 0;
    int                comparisons = 0;
    int                cycles      = 0;
    wire logic [31:0]  rdata;
    wire logic [10:0]  so;
    wire logic         gate_a;
    wire logic         gate_b;
    wire logic [2:0]   tx_n;
    wire logic [2:0]   sel_n;

    always #25 mclk_in = ~mclk_in;

    gpr_console u_console (.mclk_in(mclk_in), .load_in(load),
        .single_in(single), .line_in(line), .pat_in(pat),
        .gate_a_out(gate_a), .gate_b_out(gate_b),
        .tx_gate_n_out(tx_n), .sel_n_out(sel_n));

    gpr_router dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .rx_gate_in_a_in(gate_a), .rx_gate_in_b_in(gate_b),
        .tx_gate_in_ch1_n_in(tx_n[0]), .tx_gate_in_ch2_n_in(tx_n[1]),
        .tx_gate_in_ch3_n_in(tx_n[2]), .observe_sel_ch1_n_in(sel_n[0]),
        .observe_sel_ch2_n_in(sel_n[1]), .observe_sel_ch3_n_in(sel_n[2]),
        .tx_polarity_jumper_in(jmp[3]), .rx_polarity_jumper_in(jmp[2]),
        .pulse_count_jumper_in(jmp[1]), .select_mode_jumper_in(jmp[0]),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata),
        .receiver_pulse_out(so[10]), .observe_pulse_ch3_out(so[9]),
        .observe_pulse_ch2_out(so[8]), .observe_pulse_ch1_out(so[7]),
        .tx_switch_ch3_out(so[6]), .tx_switch_ch2_out(so[5]),
        .tx_switch_ch1_out(so[4]), .osc_path_sel3_n_out(so[3]),
        .osc_path_sel2_n_out(so[2]), .osc_path_sel1_n_out(so[1]),
        .osc_path_enable_out(so[0]));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // p = {a, b, tx_n[2:0], sel_n[2:0]} as seen on the pins
    function automatic gpr_out_s model(logic [7:0] p, logic [3:0] c);
        gpr_out_s   o;
        logic       a;
        logic       b;
        logic       ch;
        logic [2:0] ob;
        a  = p[7] ^ c[2];
        b  = p[6] ^ c[2];
        ch = c[1] ? a : b;
        ob = ~p[2:0];
        o.receiver_pulse = a;
        o.tx_switch = p[5:3] ^ {3{c[3]}};
        if (c[0]) begin
            o.observe_pulse[0] = (ob == 3'h1) && ch;
            o.observe_pulse[1] = (ob == 3'h2) && ch;
            o.observe_pulse[2] = (ob == 3'h4) && ch;
        end else begin
            o.observe_pulse = {1'b0, ob[1] & ch, ~ob[1] & ch};
        end
        o.osc_path_sel_n  = ~o.observe_pulse;
        o.osc_path_enable = |o.observe_pulse;
        return o;
    endfunction : model

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_write(logic [7:0] a, logic [31:0] d);
        @(posedge mclk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk_in);
        wr    <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk_in);
        rd   <= 1'b0;
        @(negedge mclk_in);
        d = rdata;
    endtask : reg_read

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // a hang shows as a run far beyond 400 steps of about 11 clocks
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        logic [31:0] r;
        logic [31:0] d;
        logic [3:0]  cfg;
        logic [7:0]  pe;
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        @(negedge mclk_in);
        check("idle outputs", {21'h0, so}, {21'h0, model(8'hff, 4'hf)});
        reg_read(GPR_ADDR_CTRL, d);
        check("ctrl reset", d, {27'h0, GPR_CTRL_RST});
        reg_write(8'h0c, 32'hffffffff);
        reg_read(8'h08, d);
        check("unmapped read", d, 32'h0);
        reg_read(GPR_ADDR_CTRL, d);
        check("ctrl after stray write", d, 32'h0);
        for (int i = 0; i < 400; i++) begin
            r = xs();
            if (i % 8 == 7) begin
                ctrl = r[28:24];
                reg_write(GPR_ADDR_CTRL, {r[31:29], 24'h0, ctrl});
                reg_read(GPR_ADDR_CTRL, d);
                check("ctrl", d, {27'h0, ctrl});
            end
            cfg = ctrl[0] ? ctrl[4:1] : r[11:8];
            pe  = r[7:0];
            if (!cfg[0]) begin
                pe[1] = r[12];
            end
            @(posedge mclk_in);
            jmp    <= r[11:8];
            pat    <= r[7:0];
            single <= ~cfg[0];
            line   <= r[12];
            load   <= 1'b1;
            @(posedge mclk_in);
            load   <= 1'b0;
            repeat (8) @(posedge mclk_in);
            @(negedge mclk_in);
            check("outputs", {21'h0, so}, {21'h0, model(pe, cfg)});
            if (i % 4 == 0) begin
                reg_read(GPR_ADDR_STATUS, d);
                check("status", d, {13'h0, model(pe, cfg), r[11:8], cfg});
            end
        end
        test_done();
    end
endmodule : gpr_router_tb

`default_nettype wire
